// ### cpu_clock_defines.vh
// Offsets, field positions and reset values of the CPU clock block
`ifndef CPU_CLOCK_DEFINES_VH
`define CPU_CLOCK_DEFINES_VH

`define ADDR_BUS_CONFIG 4'h0
`define ADDR_RESET_CONFIG 4'h4
`define ADDR_CYCLE_LEN 4'h8
`define ADDR_CYCLE_CTRL 4'hC

`define MCTC_LSB 0
`define MCTC_MSB 3
`define MTTC_BIT 4
`define ALECTL_LSB 5
`define ALECTL_MSB 6
`define BUS_CONFIG_RESET 7'h00
`define BUS_CONFIG_MASK 16'h007F

`define CLKMODE_MSB 7
`define CLKMODE_LSB 5
`define CLKMODE_PRESCALE_BIT 7

`define CTRL_START_BIT 0
`define CTRL_BUSY_BIT 1

`define BASE_CYCLE_TCL 6'h06
`define MCTC_MAX 6'h0F
`define MTTC_MAX 6'h01
`define LOAD_DELAY 2'h3

`endif

// ### bit_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire rstn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ### cpu_clock_ctrl.v
// CPU clock mode selection and external bus cycle length
`timescale 1ns/1ps
`include "cpu_clock_defines.vh"

// Notes on behaviour
// - The clock generation mode is taken from bits 7 to 5 of the reset configuration register.
// - After a long hardware reset that register is loaded from the upper port 0 pins.
// - With the top mode bit clear the CPU clock follows the oscillator directly, PLL off.
// - Every CPU clock edge, rising or falling, is a half-clock tick that advances operations.
// - In direct mode two consecutive half-clock periods always make one oscillator period.
// - Latch extension, waitstate and tristate terms come from the bus configuration fields.
// - Extension is the extend count, waitstates 2 x (15 - cycle), tristate 2 x (1 - field).
// - A bus cycle lasts 6 half-clocks plus twice the extension plus waitstates plus tristate.
module cpu_clock_ctrl (
    input wire clock,
    input wire rstn,
    input wire osc_pin,
    input wire [7:0] port0_upper_half,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_r,
    output reg cpu_clk_r,
    output reg half_tick_r,
    output reg pll_enable_r,
    output reg [2:0] clock_mode_select_r,
    output reg [5:0] cycle_len_r,
    output reg cycle_busy_r,
    output reg cycle_done_r
);
    // Cycle length in half-clock periods from the bus configuration fields
    function [5:0] cycle_len;
        input [1:0] alectl;
        input [3:0] mctc;
        input mttc;
        reg [5:0] ext;
        reg [5:0] wait_t;
        reg [5:0] tri_t;
        begin
            ext = {4'h0, alectl};
            wait_t = (`MCTC_MAX - {2'h0, mctc}) << 1;
            tri_t = (`MTTC_MAX - {5'h00, mttc}) << 1;
            cycle_len = `BASE_CYCLE_TCL + (ext << 1) + wait_t + tri_t;
        end
    endfunction

    wire osc_sync;
    wire [7:0] port0_sync;
    reg osc_prev_r;
    reg [7:0] reset_config_upper_r;
    reg [1:0] load_cnt_r;
    reg load_done_r;
    reg [6:0] bus_config_regs_r;
    reg [5:0] tick_cnt_r;
    wire prescale;
    wire osc_rise;
    wire osc_edge;
    wire tick_nxt;
    wire [5:0] len_nxt;

    bit_sync #(.WIDTH(1)) u_osc_sync (
        .clock(clock),
        .rstn(rstn),
        .async_in(osc_pin),
        .sync_out(osc_sync)
    );

    bit_sync #(.WIDTH(8)) u_port_sync (
        .clock(clock),
        .rstn(rstn),
        .async_in(port0_upper_half),
        .sync_out(port0_sync)
    );

    // prescale from the top mode bit
    assign prescale = reset_config_upper_r[`CLKMODE_PRESCALE_BIT];
    assign osc_rise = osc_sync & ~osc_prev_r;
    // Against the CPU clock, so a pin already high at strap load still ticks
    assign osc_edge = osc_sync ^ cpu_clk_r;
    // each CPU edge is a tick
    assign tick_nxt = load_done_r & (prescale ? osc_rise : osc_edge);
    assign len_nxt = cycle_len(bus_config_regs_r[`ALECTL_MSB:`ALECTL_LSB],
                               bus_config_regs_r[`MCTC_MSB:`MCTC_LSB],
                               bus_config_regs_r[`MTTC_BIT]);

    // Strap capture waits for the synchroniser to fill after release
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            load_cnt_r <= `LOAD_DELAY;
            load_done_r <= 1'b0;
            reset_config_upper_r <= 8'h00;
        end
        else if (!load_done_r)
        begin
            load_cnt_r <= load_cnt_r - 2'h1;
            if (load_cnt_r == 2'h0)
            begin
                reset_config_upper_r <= port0_sync;
                load_done_r <= 1'b1;
            end
        end
    end

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            osc_prev_r <= 1'b0;
            cpu_clk_r <= 1'b0;
            half_tick_r <= 1'b0;
            pll_enable_r <= 1'b0;
            clock_mode_select_r <= 3'h0;
        end
        else
        begin
            osc_prev_r <= osc_sync;
            half_tick_r <= tick_nxt;
            clock_mode_select_r <= reset_config_upper_r[`CLKMODE_MSB:`CLKMODE_LSB];
            // PLL stays off in direct mode
            pll_enable_r <= 1'b0;
            if (load_done_r)
            begin
                if (prescale)
                begin
                    if (osc_rise)
                        cpu_clk_r <= ~cpu_clk_r;
                end
                else
                begin
                    // follow oscillator, high plus low is one period
                    cpu_clk_r <= osc_sync;
                end
            end
        end
    end

    // Bus cycle timer counts half-clock ticks; a start while busy is ignored
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_config_regs_r <= `BUS_CONFIG_RESET;
            cycle_len_r <= 6'h00;
            cycle_busy_r <= 1'b0;
            cycle_done_r <= 1'b0;
            tick_cnt_r <= 6'h00;
        end
        else
        begin
            cycle_len_r <= len_nxt;
            cycle_done_r <= 1'b0;
            if (reg_wr && reg_addr == `ADDR_BUS_CONFIG)
                bus_config_regs_r <= reg_wdata[6:0];
            if (cycle_busy_r)
            begin
                if (half_tick_r)
                begin
                    // end after full length of ticks
                    if (tick_cnt_r == cycle_len_r - 6'h01)
                    begin
                        cycle_busy_r <= 1'b0;
                        cycle_done_r <= 1'b1;
                        tick_cnt_r <= 6'h00;
                    end
                    else
                        tick_cnt_r <= tick_cnt_r + 6'h01;
                end
            end
            else if (reg_wr && reg_addr == `ADDR_CYCLE_CTRL && reg_wdata[`CTRL_START_BIT])
            begin
                cycle_busy_r <= 1'b1;
                tick_cnt_r <= 6'h00;
            end
        end
    end

    // Read data valid in the cycle after the strobe only
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            reg_rdata_r <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_BUS_CONFIG: reg_rdata_r <= {9'h000, bus_config_regs_r};
                `ADDR_RESET_CONFIG: reg_rdata_r <= {8'h00, reset_config_upper_r};
                `ADDR_CYCLE_LEN: reg_rdata_r <= {10'h000, cycle_len_r};
                `ADDR_CYCLE_CTRL: reg_rdata_r <= {14'h0000, cycle_busy_r, 1'b0};
                default: reg_rdata_r <= 16'h0000;
            endcase
        end
        else
            reg_rdata_r <= 16'h0000;
    end
endmodule

// ### cpu_clock_ctrl_assertions.sv
// Checker of clock mode, half-clock ticks and bus cycle timing
`timescale 1ns/1ps
module cpu_clock_checker (
    input wire clock,
    input wire rstn,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata_r,
    input wire cpu_clk_r,
    input wire half_tick_r,
    input wire pll_enable_r,
    input wire [2:0] clock_mode_select_r,
    input wire [5:0] cycle_len_r,
    input wire cycle_busy_r,
    input wire cycle_done_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_pll_off: assert property (
        !pll_enable_r) else $error("pll enabled");
    a_mode_held: assert property (
        $past(clock_mode_select_r) |-> $stable(clock_mode_select_r)) else $error("mode moved");
    a_tick_edge: assert property (
        half_tick_r == $changed(cpu_clk_r)) else $error("tick without edge");
    a_len_range: assert property (
        $past(rstn) |->
        cycle_len_r >= 6'h06 && cycle_len_r <= 6'h2C && !cycle_len_r[0])
        else $error("bad len");
    a_done_pulse: assert property (
        cycle_done_r |=> !cycle_done_r) else $error("done too long");
    a_fall_tick: assert property (
        $fell(cycle_busy_r) |-> $past(half_tick_r)) else $error("end off tick");
    a_start_busy: assert property (
        !cycle_busy_r && reg_wr && reg_addr == 4'hC && reg_wdata[0] |=> cycle_busy_r)
        else $error("no start");
    a_mode_read: assert property (
        reg_rd && reg_addr == 4'h4 |=> reg_rdata_r[7:5] == clock_mode_select_r)
        else $error("mode");
endmodule
bind cpu_clock_ctrl cpu_clock_checker cpu_clock_checker_inst (.clock, .rstn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .cpu_clk_r, .half_tick_r, .pll_enable_r,
    .clock_mode_select_r, .cycle_len_r, .cycle_busy_r, .cycle_done_r);

// ### osc_model.sv
// Oscillator source with settable high and low times
`timescale 1ns/1ps
module osc_model (
    input wire clock,
    input wire run,
    input wire [3:0] hi,
    input wire [3:0] lo,
    output reg osc_pin = 1'b0
);
    reg [3:0] cnt_r = 4'h0;
    // Uneven duty on purpose; level frozen while stopped
    always @(posedge clock)
        if (run)
        begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r + 4'h1 >= (osc_pin ? hi : lo))
            begin
                osc_pin <= !osc_pin;
                cnt_r <= 4'h0;
            end
        end
endmodule

// ### cpu_clock_ctrl_tb.sv
// Testbench of CPU clock mode and bus cycle timing
`timescale 1ns/1ps
module cpu_clock_ctrl_tb;
    reg clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, run = 1, lvl = 0;
    reg [7:0] port0_upper_half = 8'hA5;
    reg [3:0] reg_addr = 4'h0, hi = 4'h3, lo = 4'h5;
    reg [15:0] reg_wdata = 16'h0000;
    wire osc_pin, cpu_clk_r, half_tick_r, pll_enable_r, cycle_busy_r, cycle_done_r;
    wire [15:0] reg_rdata_r;
    wire [2:0] clock_mode_select_r;
    wire [5:0] cycle_len_r;
    integer fail_count = 0, num_checks = 0, cyc = 0, a, b;
    initial forever #50 clock = !clock;
    osc_model osc_model_inst (.clock, .run, .hi, .lo, .osc_pin);
    cpu_clock_ctrl cpu_clock_ctrl_inst (.clock, .rstn, .osc_pin, .port0_upper_half, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .cpu_clk_r, .half_tick_r, .pll_enable_r,
        .clock_mode_select_r, .cycle_len_r, .cycle_busy_r, .cycle_done_r);
    task chk(input [15:0] got, input [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Pins flipped after the load, so a late resample shows up
    task rst(input [7:0] s);
        port0_upper_half <= s;
        rstn <= 0;
        repeat (16) @(posedge clock);
        rstn <= 1;
        repeat (8) @(posedge clock);
        port0_upper_half <= ~s;
    endtask
    task wr(input [3:0] ad, input [15:0] d);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clock);
        reg_wr <= 0;
    endtask
    task rd(input [3:0] ad, input [15:0] e);
        @(posedge clock);
        reg_addr <= ad;
        reg_rd <= 1;
        @(posedge clock);
        reg_rd <= 0;
        @(posedge clock);
        chk(reg_rdata_r, e);
    endtask
    task gap(output integer n);
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (half_tick_r !== 1 && n < 99);
    endtask
    task t_cfg(input [15:0] c);
        wr(4'h0, c);
        rd(4'h0, c);
        rd(4'h8, 6 + 2 * c[6:5] + 2 * (15 - c[3:0]) + 2 * (1 - c[4]));
    endtask
    task t_prescale;
        rst(8'hA5);
        chk(clock_mode_select_r, 3'h5);
        rd(4'h4, 16'h00A5);
        gap(a);
        lvl = cpu_clk_r;
        gap(a);
        chk(cpu_clk_r, !lvl);
        gap(b);
        chk(a + b, 16);
        $display("prescale test done");
    endtask
    task t_direct;
        rst(8'h5A);
        chk(clock_mode_select_r, 3'h2);
        chk(pll_enable_r, 0);
        gap(a);
        lvl = cpu_clk_r;
        gap(a);
        chk(cpu_clk_r, !lvl);
        gap(b);
        chk(a + b, 8);
        chk(a == b, 0);
        $display("direct test done");
    endtask
    task t_length;
        rd(4'h8, 16'h0026);
        t_cfg(16'h007F);
        t_cfg(16'h0060);
        t_cfg(16'h0035);
        t_cfg(16'h001F);
        rd(4'h2, 16'h0000);
        $display("length test done");
    endtask
    // Oscillator parked so no tick is half counted at the start
    task t_cycle;
        run <= 0;
        repeat (5) @(posedge clock);
        wr(4'hC, 16'h0001);
        rd(4'hC, 16'h0002);
        run <= 1;
        a = 0;
        b = 0;
        while (cycle_done_r !== 1 && b < 300)
        begin
            @(posedge clock);
            b++;
            a = a + (half_tick_r === 1);
        end
        chk(a, 6);
        chk(cycle_busy_r, 0);
        $display("cycle test done");
    endtask
    initial
    begin
        t_prescale;
        t_direct;
        t_length;
        t_cycle;
        results;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            results;
        end
    end
endmodule
